// ===== rtl/vmb_bridge.sv
// module: processor to vme master bridge with region map and byte mux
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module vmb_bridge #(
  parameter int N_REGION = 4096
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  // processor memory port, longword address
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic [29:0] cpu_addr_i,
  input wire logic [3:0] cpu_be_i,
  input wire logic [31:0] cpu_wdata_i,
  output logic cpu_ack_o,
  output logic [31:0] cpu_rdata_o,
  // vme master side
  output logic vme_strb_o,
  output logic vme_write_o,
  output logic [31:0] vme_addr_o,
  output logic [1:0] vme_space_o,
  output logic [3:0] vme_lanes_o,
  output logic [31:0] vme_wdata_o,
  input wire logic [31:0] vme_rdata_i,
  input wire logic vme_dtack_i,
  input wire logic vme_berr_i
);
  typedef enum {ST_IDLE, ST_BUS, ST_DONE} vmb_state_t;

  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic [1:0] status;
  logic [1:0] next_status;
  logic [1:0] mask;
  logic [1:0] next_mask;
  logic [11:0] map_index;
  logic [11:0] next_map_index;
  logic [7:0] swap [vmb_pkg::N_SWAP];
  logic [7:0] next_swap [vmb_pkg::N_SWAP];
  logic [vmb_pkg::MAP_W-1:0] map [N_REGION];
  logic map_we;
  logic [31:0] next_rdata;
  logic [31:0] reg_rdata;

  // register decode: control, sticky status, mask, swap table, map window
  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_map_index = map_index;
    next_swap = swap;
    map_we = 1'b0;
    next_rdata = 32'h0000_0000;
    if (reg_wr_i) begin
      if (reg_addr_i == vmb_pkg::OFS_CTRL) next_ctrl = reg_wdata_i[1:0];
      if (reg_addr_i == vmb_pkg::OFS_MASK) next_mask = reg_wdata_i[1:0];
      if (reg_addr_i == vmb_pkg::OFS_MAP_INDEX) next_map_index = reg_wdata_i[11:0];
      if (reg_addr_i == vmb_pkg::OFS_MAP_DATA) map_we = 1'b1;
      for (int i = 0; i < vmb_pkg::N_SWAP; i++) begin
        if (reg_addr_i == vmb_pkg::OFS_SWAP_BASE + 8'(4 * i)) begin
          next_swap[i] = reg_wdata_i[7:0];
        end
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == vmb_pkg::OFS_CTRL) next_rdata = {30'h0000_0000, ctrl};
      if (reg_addr_i == vmb_pkg::OFS_STATUS) next_rdata = {30'h0000_0000, status};
      if (reg_addr_i == vmb_pkg::OFS_MASK) next_rdata = {30'h0000_0000, mask};
      if (reg_addr_i == vmb_pkg::OFS_MAP_INDEX) next_rdata = {20'h0_0000, map_index};
      if (reg_addr_i == vmb_pkg::OFS_MAP_DATA) begin
        next_rdata = {22'h00_0000, map[map_index[$clog2(N_REGION)-1:0]]};
      end
      for (int i = 0; i < vmb_pkg::N_SWAP; i++) begin
        if (reg_addr_i == vmb_pkg::OFS_SWAP_BASE + 8'(4 * i)) begin
          next_rdata = {24'h00_0000, swap[i]};
        end
      end
    end
  end

  // register file flops; swap entries reset to straight-through
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= vmb_pkg::CTRL_RESET;
      mask <= 2'h0;
      map_index <= 12'h000;
      reg_rdata <= 32'h0000_0000;
      for (int i = 0; i < vmb_pkg::N_SWAP; i++) swap[i] <= vmb_pkg::SWAP_IDENTITY;
    end else begin
      ctrl <= next_ctrl;
      mask <= next_mask;
      map_index <= next_map_index;
      reg_rdata <= next_rdata;
      swap <= next_swap;
    end
  end
  assign reg_rdata_o = reg_rdata;

  // map storage, one entry per megabyte; no reset so it stays a plain table
  always_ff @(posedge ref_clk_i) begin
    if (map_we) map[map_index[$clog2(N_REGION)-1:0]] <= reg_wdata_i[vmb_pkg::MAP_W-1:0];
  end

  // ---- master cycle path ----
  vmb_state_t state;
  vmb_state_t next_state;
  logic [vmb_pkg::MAP_W-1:0] ent;
  logic [1:0] space;
  logic [1:0] size;
  logic [1:0] lowa;
  logic [2:0] fsel;
  logic [31:0] cpu_word;
  logic [31:0] vme_word;
  logic [31:0] next_vaddr;
  logic [3:0] next_lanes;
  logic [31:0] next_vwdata;
  logic [31:0] next_crdata;
  logic next_strb;
  logic next_ack;
  logic berr_ev;
  logic done_ev;
  logic start;
  logic [31:0] vaddr;
  logic [3:0] lanes;
  logic [31:0] vwdata;
  logic [31:0] crdata;
  logic strb;
  logic ack;
  logic vwrite;
  logic [1:0] vspace;
  logic [2:0] cur_fsel;
  logic [7:0] rsel;
  vmb_swap_if sw_wr ();
  vmb_swap_if sw_rd ();

  // region lookup by top processor address bits
  assign ent = map[cpu_addr_i[29 -: vmb_pkg::REGION_BITS]];
  assign space = ent[vmb_pkg::MAP_SPACE_LSB +: 2];
  assign size = ent[vmb_pkg::MAP_SIZE_LSB +: 2];
  assign lowa = ent[vmb_pkg::MAP_LOWA_LSB +: 2];
  assign fsel = ent[vmb_pkg::MAP_SWAP_LSB +: 3];
  // only a valid entry with master enabled starts a vme cycle
  assign start = cpu_req_i && ent[vmb_pkg::MAP_VALID_BIT]
    && ctrl[vmb_pkg::CTRL_MASTER_EN_BIT];

  // write data goes through the mux; disabled mux is transparent
  assign sw_wr.din = cpu_wdata_i;
  assign sw_wr.sel = ctrl[vmb_pkg::CTRL_MUX_EN_BIT] ? swap[fsel]
    : vmb_pkg::SWAP_IDENTITY;
  assign cpu_word = sw_wr.dout;
  vmb_byte_mux u_mux_wr (.sw(sw_wr.mux));

  // read data uses the function latched at cycle start
  assign rsel = ctrl[vmb_pkg::CTRL_MUX_EN_BIT] ? swap[cur_fsel] : vmb_pkg::SWAP_IDENTITY;
  assign sw_rd.din = vme_rdata_i;
  assign sw_rd.sel = rsel;
  assign vme_word = sw_rd.dout;
  vmb_byte_mux u_mux_rd (.sw(sw_rd.mux));

  // cycle control: idle, wait on vme, one-cycle acknowledge to processor
  always_comb begin
    next_state = state;
    next_vaddr = vaddr;
    next_lanes = lanes;
    next_vwdata = vwdata;
    next_crdata = crdata;
    next_strb = strb;
    next_ack = 1'b0;
    berr_ev = 1'b0;
    done_ev = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_BUS;
          next_strb = 1'b1;
          next_vwdata = cpu_word;
          // address: longword bits plus low bits from the map
          next_vaddr = {cpu_addr_i, lowa};
          if (space == 2'(vmb_pkg::SP_A16)) next_vaddr[31:16] = 16'h0000;
          if (space == 2'(vmb_pkg::SP_A24)) next_vaddr[31:24] = 8'h00;
          // lanes, bit 3 is byte 0 (msb) in big-endian numbering
          case (size)
            2'(vmb_pkg::SZ_D16): next_lanes = lowa[1] ? 4'h3 : 4'hC;
            2'(vmb_pkg::SZ_D08): next_lanes = 4'h8 >> lowa;
            default: begin
              next_lanes = 4'hF;
              // a lone byte write in a D32 region becomes a D08 cycle
              if (cpu_we_i && cpu_be_i != 4'hF) begin
                next_lanes = cpu_be_i;
                next_vaddr[1:0] = cpu_be_i[3] ? 2'h0 : cpu_be_i[2] ? 2'h1
                  : cpu_be_i[1] ? 2'h2 : 2'h3;
              end
            end
          endcase
        end
      end
      ST_BUS: begin
        // hold the processor until acknowledge or bus error
        if (vme_dtack_i || vme_berr_i) begin
          next_strb = 1'b0;
          next_ack = 1'b1;
          next_state = ST_DONE;
          next_crdata = vme_word;
          berr_ev = vme_berr_i;
          done_ev = 1'b1;
        end
      end
      ST_DONE: next_state = ST_IDLE; // one turnaround cycle back to idle, request not looked at
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      vaddr <= 32'h0000_0000;
      lanes <= 4'h0;
      vwdata <= 32'h0000_0000;
      crdata <= 32'h0000_0000;
      strb <= 1'b0;
      ack <= 1'b0;
      vwrite <= 1'b0;
      vspace <= 2'h0;
      cur_fsel <= 3'h0;
    end else begin
      state <= next_state;
      vaddr <= next_vaddr;
      lanes <= next_lanes;
      vwdata <= next_vwdata;
      crdata <= next_crdata;
      strb <= next_strb;
      ack <= next_ack;
      if (state == ST_IDLE && start) begin
        vwrite <= cpu_we_i;
        vspace <= space;
        cur_fsel <= fsel;
      end
    end
  end

  // sticky status: an event in the read cycle survives the clear
  always_comb begin
    next_status = status;
    if (reg_rd_i && reg_addr_i == vmb_pkg::OFS_STATUS) next_status = 2'h0;
    if (berr_ev) next_status[vmb_pkg::STAT_BERR_BIT] = 1'b1;
    if (done_ev) next_status[vmb_pkg::STAT_DONE_BIT] = 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) status <= 2'h0;
    else status <= next_status;
  end

  assign irq_o = |(status & mask);
  assign cpu_ack_o = ack;
  assign cpu_rdata_o = crdata;
  assign vme_strb_o = strb;
  assign vme_write_o = vwrite;
  assign vme_addr_o = vaddr;
  assign vme_space_o = vspace;
  assign vme_lanes_o = lanes;
  assign vme_wdata_o = vwdata;
endmodule // vmb_bridge

// ===== rtl/vmb_pkg.sv
// package: constants and types of the vme master byte mux bridge
package vmb_pkg;
  // register offsets on the plain register port (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_SWAP_BASE = 8'h20;
  localparam logic [7:0] OFS_MAP_INDEX = 8'h40;
  localparam logic [7:0] OFS_MAP_DATA = 8'h44;
  // control fields
  localparam int CTRL_MUX_EN_BIT = 0;
  localparam int CTRL_MASTER_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // status fields
  localparam int STAT_BERR_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  // map entry fields
  localparam int MAP_VALID_BIT = 0;
  localparam int MAP_SPACE_LSB = 1;
  localparam int MAP_SIZE_LSB = 3;
  localparam int MAP_LOWA_LSB = 5;
  localparam int MAP_SWAP_LSB = 7;
  localparam int MAP_W = 10;
  localparam logic [9:0] MAP_RESET = 10'h000;
  // swap function: four 2-bit source byte selects
  localparam logic [7:0] SWAP_IDENTITY = 8'hE4;
  localparam int N_SWAP = 8;
  localparam int REGION_BITS = 12;
  // address space and data size codes
  typedef enum logic [1:0] {SP_A16, SP_A24, SP_A32} vmb_space_t;
  typedef enum logic [1:0] {SZ_D32, SZ_D16, SZ_D08} vmb_size_t;
endpackage

// ===== rtl/vmb_swap_if.sv
// interface: data path between bridge core and byte multiplexor
`timescale 1ns/1ns
interface vmb_swap_if;
  logic [31:0] din;
  logic [7:0] sel;
  logic [31:0] dout;
  modport core (output din, output sel, input dout);
  modport mux (input din, input sel, output dout);
endinterface

// ===== rtl/vmb_byte_mux.sv
// module: four byte permutation transceiver
`timescale 1ns/1ns
module vmb_byte_mux (
  vmb_swap_if.mux sw
);
  // each output byte picks any input byte, so any permutation is reachable
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      always_comb begin
        sw.dout[8*g +: 8] = sw.din[8*sw.sel[2*g +: 2] +: 8];
      end
    end
  endgenerate
endmodule // vmb_byte_mux

// ===== tb/vmb_vme_slave.sv
// vme slave model: wait states, bus error, one stored longword
`timescale 1ns/1ns
module vmb_vme_slave (
  input wire logic ref_clk_i,
  input wire logic strb_i,
  input wire logic write_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wait_i,
  input wire logic berr_en_i,
  output logic [31:0] rdata_o,
  output logic dtack_o,
  output logic berr_o
);
  logic [3:0] cnt;
  logic [31:0] mem;
  // wait states counted while selected; answer held until strobe drops
  always @(posedge ref_clk_i) begin
    cnt <= strb_i ? cnt + 4'(cnt != wait_i) : 4'h0;
    if (dtack_o && write_i)
      mem <= wdata_i;
  end
  assign dtack_o = strb_i && cnt == wait_i && !berr_en_i;
  assign berr_o = strb_i && cnt == wait_i && berr_en_i;
  // released bus shows the inverse, never a stale copy
  assign rdata_o = (strb_i && !write_i) ? mem : ~mem;
endmodule // vmb_vme_slave

// ===== tb/vmb_bridge_props.sv
// checker: port assertions of the vme master bridge
`timescale 1ns/1ns
module vmb_bridge_props (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cpu_req_i,
  input wire logic cpu_ack_o,
  input wire logic vme_strb_o,
  input wire logic [31:0] vme_addr_o,
  input wire logic [1:0] vme_space_o,
  input wire logic [3:0] vme_lanes_o,
  input wire logic vme_dtack_i,
  input wire logic vme_berr_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // cycle framing: answer closes it, nothing else does
  property p_close;
    vme_strb_o && (vme_dtack_i || vme_berr_i) |=> !vme_strb_o && cpu_ack_o;
  endproperty
  a_close: assert property (p_close) else $error("cycle not closed");
  property p_wait;
    vme_strb_o && !vme_dtack_i && !vme_berr_i |=> vme_strb_o;
  endproperty
  a_wait: assert property (p_wait) else $error("cycle dropped early");
  property p_ack;
    cpu_ack_o |-> $past(vme_strb_o) && ($past(vme_dtack_i) || $past(vme_berr_i));
  endproperty
  a_ack: assert property (p_ack) else $error("ack without answer");
  property p_start;
    $rose(vme_strb_o) |-> $past(cpu_req_i);
  endproperty
  a_start: assert property (p_start) else $error("cycle without request");
  property p_hold;
    vme_strb_o && $past(vme_strb_o) |-> $stable(vme_addr_o) && $stable(vme_lanes_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  // short spaces drop the upper address bits
  property p_a16;
    vme_strb_o && vme_space_o == 2'h0 |-> vme_addr_o[31:16] == 16'h0000;
  endproperty
  a_a16: assert property (p_a16) else $error("a16 upper bits");
  property p_a24;
    vme_strb_o && vme_space_o == 2'h1 |-> vme_addr_o[31:24] == 8'h00;
  endproperty
  a_a24: assert property (p_a24) else $error("a24 upper bits");
  property p_lanes;
    vme_strb_o |-> vme_lanes_o != 4'h0;
  endproperty
  a_lanes: assert property (p_lanes) else $error("no lane");
endmodule // vmb_bridge_props
bind vmb_bridge vmb_bridge_props i_props (.ref_clk_i, .arst_n_i, .cpu_req_i, .cpu_ack_o,
  .vme_strb_o, .vme_addr_o, .vme_space_o, .vme_lanes_o, .vme_dtack_i, .vme_berr_i);

// ===== tb/tb_vme_master_byte_mux_bridge.sv
// testbench: map, master cycle, byte mux and bus error tests
`timescale 1ns/1ns
module tb_vme_master_byte_mux_bridge;
  logic ref_clk_i = 1'b0, arst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, cpu_req_i = 1'b0;
  logic cpu_we_i = 1'b0, berr_en = 1'b0, irq_o, cpu_ack_o, vme_strb_o, vme_write_o;
  logic vme_dtack_i, vme_berr_i, v_wr;
  logic [7:0] reg_addr_i = 8'h00;
  logic [3:0] cpu_be_i = 4'h0, wt = 4'h0, vme_lanes_o, v_lanes;
  logic [1:0] vme_space_o, sp, sz, lw, v_sp;
  logic [29:0] cpu_addr_i = 30'h0, a;
  logic [31:0] reg_wdata_i = 32'h0, cpu_wdata_i = 32'h0, reg_rdata_o, cpu_rdata_o, vme_addr_o;
  logic [31:0] vme_wdata_o, vme_rdata_i, v_addr, v_wd, rdat, r, msk;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  vmb_bridge i_dut (.ref_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .irq_o, .cpu_req_i, .cpu_we_i, .cpu_addr_i, .cpu_be_i, .cpu_wdata_i, .cpu_ack_o,
    .cpu_rdata_o, .vme_strb_o, .vme_write_o, .vme_addr_o, .vme_space_o, .vme_lanes_o,
    .vme_wdata_o, .vme_rdata_i, .vme_dtack_i, .vme_berr_i);
  vmb_vme_slave i_slv (.ref_clk_i(ref_clk_i), .strb_i(vme_strb_o), .write_i(vme_write_o),
    .wdata_i(vme_wdata_o), .wait_i(wt), .berr_en_i(berr_en), .rdata_o(vme_rdata_i),
    .dtack_o(vme_dtack_i), .berr_o(vme_berr_i));
  // verdict in one place
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // register port: one-cycle strobes, read data the cycle after
  task automatic rw(input logic [7:0] ad, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rr(input logic [7:0] ad);
    @(posedge ref_clk_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 r = reg_rdata_o;
  endtask
  // processor cycle: request held until ack, dropped inside the ack cycle
  task automatic cpu(input logic we, input logic [29:0] ad, input logic [3:0] be,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cpu_req_i <= 1'b1;
    cpu_we_i <= we;
    cpu_addr_i <= ad;
    cpu_be_i <= be;
    cpu_wdata_i <= d;
    while (vme_strb_o !== 1'b1 && n < 40) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    v_addr = vme_addr_o;
    v_lanes = vme_lanes_o;
    v_wd = vme_wdata_o;
    v_sp = vme_space_o;
    v_wr = vme_write_o;
    while (cpu_ack_o !== 1'b1 && n < 40) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    rdat = cpu_rdata_o;
    cpu_req_i <= 1'b0;
    chk(32'(n < 40), 32'h1);
  endtask
  // hang guard, well above the fewer than two hundred cycles the tests need
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rr(vmb_pkg::OFS_CTRL);
    chk(r, 32'h0);
    rr(vmb_pkg::OFS_SWAP_BASE + 8'h14);
    chk(r, 32'hE4);
    rr(8'hFC);
    chk(r, 32'h0);
    rw(vmb_pkg::OFS_CTRL, 32'h2);
    // every space, size and byte selection; mux still off, swap 5 ignored
    for (int i = 0; i < 8; i++) begin
      sp = (i == 0 || i == 7) ? 2'h2 : (i == 2) ? 2'h0 : 2'h1;
      sz = (i == 0 || i == 7) ? 2'h0 : (i < 3) ? 2'h1 : 2'h2;
      lw = (i > 2 && i < 7) ? 2'(i - 3) : (i == 2) ? 2'h2 : 2'h0;
      msk = (sp == 2'h0) ? 32'h0000FFFF : (sp == 2'h1) ? 32'h00FFFFFF : 32'hFFFFFFFF;
      a = {12'(16 + i), 18'h00123};
      wt <= 4'(i);
      rw(vmb_pkg::OFS_MAP_INDEX, 32'(16 + i));
      rw(vmb_pkg::OFS_MAP_DATA, {22'h0, 3'h5, lw, sz, sp, 1'b1});
      rr(vmb_pkg::OFS_MAP_DATA);
      chk(r, {22'h0, 3'h5, lw, sz, sp, 1'b1});
      // byte write only with the mux off, so the lane it lands on is defined
      cpu(1'b1, a, (i == 7) ? 4'h4 : 4'hF, 32'h11223344);
      chk(32'(v_sp), 32'(sp));
      chk(32'(v_wr), 32'h1);
      chk(v_addr, {a, (i == 7) ? 2'h1 : lw} & msk);
      chk(32'(v_lanes), (i == 7) ? 32'h4 : (sz == 2'h0) ? 32'hF : (sz == 2'h1) ?
        (lw[1] ? 32'h3 : 32'hC) : 32'(4'h8 >> lw));
      if (sz == 2'h0)
        chk(v_wd, 32'h11223344);
    end
    $display("test map done");
    a = {12'h010, 18'h00123};
    wt <= 4'h0;
    rw(vmb_pkg::OFS_SWAP_BASE + 8'h14, 32'h1B);
    rw(vmb_pkg::OFS_CTRL, 32'h3);
    // whole-word accesses only while reordering is active
    cpu(1'b1, a, 4'hF, 32'h11223344);
    chk(v_wd, 32'h44332211);
    cpu(1'b0, a, 4'hF, 32'h0);
    chk(rdat, 32'h11223344);
    chk(32'(v_wr), 32'h0);
    rw(vmb_pkg::OFS_SWAP_BASE + 8'h14, 32'hE4);
    cpu(1'b1, a, 4'hF, 32'h11223344);
    chk(v_wd, 32'h11223344);
    $display("test mux done");
    rr(vmb_pkg::OFS_STATUS);
    rw(vmb_pkg::OFS_MASK, 32'h1);
    berr_en <= 1'b1;
    cpu(1'b0, a, 4'hF, 32'h0);
    berr_en <= 1'b0;
    chk(32'(irq_o), 32'h1);
    rw(vmb_pkg::OFS_MASK, 32'h0);
    chk(32'(irq_o), 32'h0);
    rw(vmb_pkg::OFS_MASK, 32'h1);
    rr(vmb_pkg::OFS_STATUS);
    chk(r, 32'h3);
    chk(32'(irq_o), 32'h0);
    $display("test bus error done");
    summarize();
  end
endmodule // tb_vme_master_byte_mux_bridge
